// File: bench/pcc_sensor_model.sv
// Purpose: Light sensor model giving one light pulse per request.
// Assumes: The request is a one-cycle strobe on ref_clk.
// Notes: The pulse outlasts the synchroniser on both edges.
`timescale 1ns/1ns
`default_nettype none
module pcc_sensor_model #(parameter int HI_CYC = 8) (
  input wire logic ref_clk, // Clock.
  input wire logic go, // Request one pulse.
  output logic pin // High while light.
);
  // ==========================================================
  // Pulse timer
  // Pulses are rare and short, far below the low-rate minimum width.
  int cnt = 0;
  always @(posedge ref_clk) begin
    if (go) begin
      cnt <= HI_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign pin = (cnt > 0);
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the preset count controller.
// Assumes: Debounce off except for the glitch test.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/1ns
`default_nettype none
`include "pcc_regs.svh"
module tb_top;
  import pcc_pkg::*;
  logic ref_clk = 0, sys_rst = 1, go = 0, pin, src = 1, prd = 0, lo = 0;
  logic dual = 1, btn = 0, ted = 0, rrst = 0, lock = 0, wr = 0, sel = 0;
  logic o1, o2, refd, saw_ref = 0;
  logic [3:0] mode = 4'hF;
  pcc_count_t wdata = 16'h0000, cnt, p1, p2;
  int n_errors = 0, compares = 0;
  // ==========================================================
  // Clock, partner and device
  always #4 ref_clk = ~ref_clk;
  pcc_sensor_model u_sens (.ref_clk(ref_clk), .go(go), .pin(pin));
  pcc_counter u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .count_pulse_input(pin), .sourcing_input_select(src),
    .low_rate_filter(lo), .high_threshold_select(1'b0),
    .panel_reset_disable(prd), .mode_switch(mode), .dual_preset(dual),
    .panel_reset_button(btn), .timed_entry_active(ted),
    .remote_reset_input(rrst), .program_lock_input(lock),
    .preset_wr(wr), .preset_sel(sel), .preset_wdata(wdata),
    .count_value(cnt), .preset1_value(p1), .preset2_value(p2),
    .output1_on(o1), .output2_on(o2), .preset_refused(refd));
  // The refusal flag lasts one cycle, so it is caught in a sticky copy.
  always @(posedge ref_clk) begin
    if (refd === 1'b1) begin
      saw_ref <= 1'b1;
    end
  end
  // ==========================================================
  // Access and compare tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk16(input pcc_count_t g, input pcc_count_t e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // One light pulse; the count is checked while the pin is still high.
  task automatic pulse(input pcc_count_t mid);
    go = 1;
    cyc(1);
    go = 0;
    cyc(5);
    chk16(cnt, mid);
    cyc(10);
  endtask
  // The refusal flag stands in the cycle after the strobe is taken.
  task automatic wr_preset(input logic s, input pcc_count_t d,
      input logic r);
    sel = s;
    wdata = d;
    wr = 1;
    cyc(1);
    chk1(refd, r);
    wr = 0;
    cyc(2);
  endtask
  task automatic press();
    btn = 1;
    cyc(6);
    btn = 0;
    cyc(4);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog, sized at many times the expected run.
  initial begin
    #100000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  // ==========================================================
  // Tests
  initial begin
    cyc(6);
    sys_rst = 0;
    cyc(2);
    chk16(p1, `PCC_PRESET1_RST);
    chk16(p2, `PCC_PRESET2_RST);
    chk16(cnt, 16'h0000);
    lock = 1;
    cyc(4);
    wr_preset(1'b0, 16'h0003, 1'b1);
    chk16(p1, `PCC_PRESET1_RST);
    chk1(saw_ref, 1'b1);
    lock = 0;
    cyc(4);
    wr_preset(1'b0, 16'h0003, 1'b0);
    wr_preset(1'b1, 16'h0005, 1'b0);
    chk16(p1, 16'h0003);
    chk16(p2, 16'h0005);
    $display("test lock done");
    src = 0;
    cyc(4);
    pulse(16'h0000);
    chk16(cnt, 16'h0001);
    src = 1;
    cyc(4);
    pulse(16'h0002);
    chk1(o1, 1'b0);
    pulse(16'h0003);
    chk1(o1, 1'b1);
    chk1(o2, 1'b0);
    pulse(16'h0004);
    pulse(16'h0005);
    chk1(o2, 1'b1);
    pulse(16'h0006);
    chk1(o1, 1'b1);
    mode = 4'hE;
    cyc(4);
    pulse(16'h0006);
    mode = 4'hF;
    $display("test count done");
    prd = 1;
    cyc(4);
    press();
    chk16(cnt, 16'h0006);
    prd = 0;
    ted = 1;
    cyc(4);
    press();
    chk16(cnt, 16'h0006);
    ted = 0;
    cyc(4);
    press();
    chk16(cnt, 16'h0000);
    chk1(o2, 1'b0);
    for (int i = 1; i <= 5; i++) begin
      pulse(16'(i));
    end
    chk1(o2, 1'b1);
    rrst = 1;
    cyc(6);
    rrst = 0;
    cyc(4);
    chk16(cnt, 16'h0000);
    chk1(o1, 1'b0);
    chk1(o2, 1'b0);
    $display("test reset done");
    dual = 0;
    cyc(4);
    for (int i = 1; i <= 5; i++) begin
      pulse(16'(i));
    end
    chk1(o1, 1'b1);
    chk1(o2, 1'b0);
    lo = 1;
    cyc(4);
    pulse(16'h0005);
    chk16(cnt, 16'h0005);
    lo = 0;
    $display("test version done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: hdl/pcc_counter.sv
// Purpose: Presettable event counter with one or two latched outputs.
// Assumes: Switches and terminals are asynchronous pins.
// Notes: Only mode zero is built; other modes hold the count except on a reset.
`timescale 1ns/1ns
`default_nettype none
`include "pcc_regs.svh"
// Behaviour
// - Sourcing: count on dark-to-light edge
// - Panel reset disabled: button ignored
// - Mode switches all up select mode zero
// - Output fires when count equals preset
// - Remote reset clears count and outputs
// - Lock asserted refuses preset changes
// - Output one fires at preset one
// - Output two fires at preset two on the dual version only; both latch
// - Front reset works unless timed entry
module pcc_counter (
  input wire logic ref_clk, // 125 MHz clock.
  input wire logic sys_rst, // Synchronous reset, high.
  input wire logic count_pulse_input, // Sensor pin, high is light.
  input wire logic sourcing_input_select, // 1 = sourcing input.
  input wire logic low_rate_filter, // 1 = low-rate debounce.
  input wire logic high_threshold_select, // Analog only, unused.
  input wire logic panel_reset_disable, // 1 = panel reset ignored.
  input wire logic [3:0] mode_switch, // 1 = switch up.
  input wire logic dual_preset, // 1 = dual version.
  input wire logic panel_reset_button, // Front reset pin.
  input wire logic timed_entry_active, // Timed-output entry mode.
  input wire logic remote_reset_input, // Remote reset pin, high.
  input wire logic program_lock_input, // 1 = lock asserted.
  input wire logic preset_wr, // Preset write strobe.
  input wire logic preset_sel, // 0 = preset one, 1 = two.
  input wire pcc_pkg::pcc_count_t preset_wdata, // New preset.
  output var pcc_pkg::pcc_count_t count_value, // Current count.
  output var pcc_pkg::pcc_count_t preset1_value, // Preset one.
  output var pcc_pkg::pcc_count_t preset2_value, // Preset two.
  output logic output1_on, // Output one.
  output logic output2_on, // Output two.
  output logic preset_refused // Write refused by lock.
);
  import pcc_pkg::*;
  typedef struct packed {
    logic in_prev;
    pcc_state_t st;
    pcc_count_t cnt;
    pcc_count_t p1;
    pcc_count_t p2;
    logic o1;
    logic o2;
    logic btn_prev;
    logic rem_prev;
    logic refused;
    logic [1:0] settle;
  } pcc_st_t;
  pcc_st_t s_r;
  pcc_st_t s_nxt;
  logic in_lvl, btn_lvl, rem_lvl, lock_lvl, srcsel_lvl, lo_lvl, dis_lvl;
  logic dual_lvl;
  logic [3:0] mode_lvl;
  logic edge_hit, do_reset, mode_zero;
  pcc_count_t cnt_inc;
  // ==========================================================
  // Pin synchronisers; count input is filtered in low-rate mode.
  pcc_sync u_in (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(lo_lvl),
    .filt_len(`PCC_FILT_W'(`PCC_LOW_FILT_CYC)),
    .pin_in(count_pulse_input), .lvl_out(in_lvl));
  pcc_sync u_btn (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
    .filt_len('0), .pin_in(panel_reset_button), .lvl_out(btn_lvl));
  pcc_sync u_rem (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
    .filt_len('0), .pin_in(remote_reset_input), .lvl_out(rem_lvl));
  pcc_sync u_lck (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
    .filt_len('0), .pin_in(program_lock_input), .lvl_out(lock_lvl));
  pcc_sync u_src (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
    .filt_len('0), .pin_in(sourcing_input_select), .lvl_out(srcsel_lvl));
  pcc_sync u_lo (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
    .filt_len('0), .pin_in(low_rate_filter), .lvl_out(lo_lvl));
  pcc_sync u_dis (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
    .filt_len('0), .pin_in(panel_reset_disable), .lvl_out(dis_lvl));
  // The version strap is a pin too, so it is synchronised like the rest.
  pcc_sync u_dual (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
    .filt_len('0), .pin_in(dual_preset), .lvl_out(dual_lvl));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mode
      pcc_sync u_m (.ref_clk(ref_clk), .sys_rst(sys_rst), .filt_en(1'b0),
        .filt_len('0), .pin_in(mode_switch[gi]), .lvl_out(mode_lvl[gi]));
    end
  endgenerate
  // ==========================================================
  // Edge choice: sourcing counts the rise to light, sinking the fall.
  assign edge_hit = srcsel_lvl ? (in_lvl && !s_r.in_prev)
                               : (!in_lvl && s_r.in_prev);
  assign mode_zero = (mode_lvl == `PCC_MODE_ZERO);
  // Reset on a remote press, or on a panel press when allowed.
  assign do_reset = (rem_lvl && !s_r.rem_prev) ||
    (btn_lvl && !s_r.btn_prev && !dis_lvl &&
    !timed_entry_active);
  assign cnt_inc = s_r.cnt + `PCC_CNT_W'(1);
  // ==========================================================
  // Next-state logic.
  always_comb begin
    s_nxt = s_r;
    s_nxt.in_prev = in_lvl;
    s_nxt.btn_prev = btn_lvl;
    s_nxt.rem_prev = rem_lvl;
    s_nxt.refused = 1'b0;
    // Preset write is gated by the lock terminal.
    if (preset_wr) begin
      if (lock_lvl) begin
        s_nxt.refused = 1'b1;
      end else if (preset_sel) begin
        s_nxt.p2 = preset_wdata;
      end else begin
        s_nxt.p1 = preset_wdata;
      end
    end
    case (s_r.st)
      PCC_IDLE: begin
        // Wait until the pin path has settled, so a sensor that idles
        // at light does not look like an edge just after reset.
        if (s_r.settle == `PCC_SETTLE_CYC) begin
          s_nxt.st = PCC_COUNT;
        end else begin
          s_nxt.settle = s_r.settle + 2'h1;
        end
      end
      PCC_COUNT, PCC_DONE: begin
        if (do_reset) begin
          s_nxt.cnt = '0;
          s_nxt.o1 = 1'b0;
          s_nxt.o2 = 1'b0;
          s_nxt.st = PCC_COUNT;
        end else if (mode_zero && edge_hit) begin
          // Count keeps going after the latch fires.
          s_nxt.cnt = cnt_inc;
          if (cnt_inc == s_r.p1) begin
            s_nxt.o1 = 1'b1;
          end
          if (dual_lvl && cnt_inc == s_r.p2) begin
            s_nxt.o2 = 1'b1;
          end
          if (cnt_inc == (dual_lvl ? s_r.p2 : s_r.p1)) begin
            s_nxt.st = PCC_DONE;
          end
        end
      end
      default: begin
        s_nxt.st = PCC_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.p1 <= `PCC_PRESET1_RST;
      s_r.p2 <= `PCC_PRESET2_RST;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign count_value = s_r.cnt;
  assign preset1_value = s_r.p1;
  assign preset2_value = s_r.p2;
  assign output1_on = s_r.o1;
  assign output2_on = s_r.o2;
  assign preset_refused = s_r.refused;
  // ==========================================================
  // Checks.
  latch_hold_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    s_r.o1 && !do_reset |=> s_r.o1)
    else $error("output one dropped");
  // Outside mode zero the count must not move except by a reset.
  mode_hold_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !mode_zero && !do_reset |=> $stable(s_r.cnt))
    else $error("count moved outside mode zero");
  remote_clear_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(rem_lvl) && s_r.st != PCC_IDLE
    |=> s_r.cnt == '0 && !s_r.o1 && !s_r.o2)
    else $error("remote reset failed");
  lock_refuse_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    preset_wr && lock_lvl |=> $stable(s_r.p1) && $stable(s_r.p2))
    else $error("locked write took");
  refuse_flag_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    preset_wr && lock_lvl |=> s_r.refused)
    else $error("refusal not flagged");
  write_take_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    preset_wr && !lock_lvl && !preset_sel
    |=> s_r.p1 == $past(preset_wdata))
    else $error("open write lost");
  panel_ignore_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    dis_lvl && !(rem_lvl && !s_r.rem_prev) && !edge_hit
    |=> $stable(s_r.cnt))
    else $error("count moved while reset disabled");
  panel_reset_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    btn_lvl && !s_r.btn_prev && !dis_lvl && !timed_entry_active
    && s_r.st != PCC_IDLE |=> s_r.cnt == '0 && !s_r.o1 && !s_r.o2)
    else $error("panel reset failed");
  fire_one_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !do_reset && mode_zero && edge_hit && cnt_inc == s_r.p1
    && s_r.st != PCC_IDLE |=> s_r.o1)
    else $error("output one late");
  fire_two_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !do_reset && mode_zero && edge_hit && dual_lvl && cnt_inc == s_r.p2
    && s_r.st != PCC_IDLE |=> s_r.o2)
    else $error("output two late");
  // A single preset unit has no second output to fire.
  single_quiet_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !dual_lvl && !s_r.o2 |=> !s_r.o2)
    else $error("output two fired on single unit");
  count_step_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    s_r.st != PCC_IDLE && !do_reset && mode_zero && edge_hit
    |=> s_r.cnt == $past(s_r.cnt) + `PCC_CNT_W'(1))
    else $error("count did not step");
  timed_block_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    timed_entry_active && !(rem_lvl && !s_r.rem_prev) && !edge_hit
    |=> $stable(s_r.cnt))
    else $error("reset during timed entry");
endmodule
`default_nettype wire

// File: hdl/pcc_sync.sv
// Purpose: Two-stage synchroniser with an optional debounce filter.
// Assumes: Asynchronous level input.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ns
`default_nettype none
`include "pcc_regs.svh"
module pcc_sync (
  input wire logic ref_clk, // Clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic filt_en, // Debounce enable.
  input wire logic [`PCC_FILT_W-1:0] filt_len, // Stable cycles.
  input wire logic pin_in, // Raw pin.
  output logic lvl_out // Clean level.
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [`PCC_FILT_W-1:0] cnt;
    logic [1:0] warm;
  } pcc_sync_st_t;
  pcc_sync_st_t st_r;
  pcc_sync_st_t st_nxt;
  // ==========================================================
  // Sync stages, then with the filter on and warm-up over, the level changes only after staying stable.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    // Right after reset the level follows the pin unfiltered, so a pin
    // that idles high is not taken for a fresh edge much later on.
    if (st_r.warm != `PCC_SETTLE_CYC) begin
      st_nxt.warm = st_r.warm + 2'h1;
    end
    if (st_r.s2 == st_r.lvl) begin
      st_nxt.cnt = '0;
    end else if (!filt_en || st_r.cnt >= filt_len ||
        st_r.warm != `PCC_SETTLE_CYC) begin
      st_nxt.lvl = st_r.s2;
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + `PCC_FILT_W'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign lvl_out = st_r.lvl;
endmodule
`default_nettype wire

// File: inc/pcc_pkg.sv
// Purpose: Types for the preset count controller.
// Assumes: Nothing beyond the header.
// Notes: Types only.
`include "pcc_regs.svh"
package pcc_pkg;
  typedef logic [`PCC_CNT_W-1:0] pcc_count_t;
  typedef logic [3:0] pcc_mode_t;
  typedef enum logic [1:0] {
    PCC_IDLE = 2'b00,
    PCC_COUNT = 2'b01,
    PCC_DONE = 2'b10
  } pcc_state_t;
endpackage

// File: inc/pcc_regs.svh
// Purpose: Constants for the preset count controller.
// Assumes: ref_clk at 125 MHz.
// Notes: Definitions only.
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
// ==========================================================
// Widths and reset values
`define PCC_CNT_W 16
`define PCC_PRESET1_RST 16'h01F4
`define PCC_PRESET2_RST 16'h03E8
`define PCC_MODE_ZERO 4'hF
// ==========================================================
// Timing
`define PCC_CLK_MHZ 125
`define PCC_LOW_MIN_PULSE_US 5000
`define PCC_LOW_FILT_CYC (`PCC_LOW_MIN_PULSE_US * `PCC_CLK_MHZ / 2)
`define PCC_FILT_W 20
// Edges after reset during which the pin path fills and is trusted as is.
`define PCC_SETTLE_CYC 2'h3
`endif
